// *** shared/sdram_pkg.sv ***
/*
  Shared constants, command and mode types for the SDRAM burst model.
  Assumes a single 20 MHz system clock; all users import sdram_pkg::*.
*/
package sdram_pkg;
  localparam int BANKS     = 4;
  localparam int BANK_W    = 2;
  localparam int DATA_W    = 16;
  localparam int ROW_W     = 12;
  localparam int COL_W     = 9;
  localparam int ADDR_W    = 12;
  localparam int FIFO_DEPTH = 4;

  // Timing, in the unit of each name.
  localparam int CLK_PERIOD_NS     = 50;
  localparam int REFRESH_WINDOW_NS = 64_000_000;
  localparam int REFRESH_ROWS      = 4096;
  localparam int REFRESH_ROW_W     = $clog2(REFRESH_ROWS);
  localparam int REFRESH_INTERVAL_CYC =
    REFRESH_WINDOW_NS / REFRESH_ROWS / CLK_PERIOD_NS;
  localparam int AUTO_PRE_CYC      = 2;

  // Address bit fields used by commands.
  localparam int AP_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BT_BIT = 3;

  // Burst length codes held in the mode register.
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Command codes on {ras_n, cas_n, we_n}.
  localparam logic [2:0] OP_MODE      = 3'h0;
  localparam logic [2:0] OP_REFRESH   = 3'h1;
  localparam logic [2:0] OP_PRECHARGE = 3'h2;
  localparam logic [2:0] OP_ACTIVATE  = 3'h3;
  localparam logic [2:0] OP_WRITE     = 3'h4;
  localparam logic [2:0] OP_READ      = 3'h5;
  localparam logic [2:0] OP_STOP      = 3'h6;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MODE, CMD_REFRESH, CMD_PRECHARGE,
    CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_STOP
  } cmd_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_POWER_DOWN, PWR_SELF_REFRESH
  } power_e;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_s;

  typedef struct packed {
    logic [2:0] burst_len;
    logic       interleave;
  } mode_s;

  // Decode of the command pins; a deselected chip reads as no operation.
  function automatic cmd_e decode_cmd(input cmd_s c);
    cmd_e r;
    r = CMD_NOP;
    if (!c.cs_n) begin
      case ({c.ras_n, c.cas_n, c.we_n})
        OP_MODE:      r = CMD_MODE;
        OP_REFRESH:   r = CMD_REFRESH;
        OP_PRECHARGE: r = CMD_PRECHARGE;
        OP_ACTIVATE:  r = CMD_ACTIVATE;
        OP_WRITE:     r = CMD_WRITE;
        OP_READ:      r = CMD_READ;
        OP_STOP:      r = CMD_STOP;
        default:      r = CMD_NOP;
      endcase
    end
    return r;
  endfunction
endpackage

// *** verilog/sync_fifo.sv ***
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk_i,   // System clock.
  input  wire logic             reset_n_i,   // Async reset, active low.
  input  wire logic             in_valid_i,  // Write request.
  output logic                  in_ready_o,  // Space available.
  input  wire logic [WIDTH-1:0] in_data_i,   // Write word.
  output logic                  out_valid_o, // Word available.
  input  wire logic             out_ready_i, // Reader takes word.
  output logic      [WIDTH-1:0] out_data_o   // Head word.
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = count_reg != CNT_W'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o  = store_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage is written only on an accepted push.
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                      : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                      : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule

// *** verilog/burst_addr_gen.sv ***
/*
  Column address of one burst beat from start column and beat count.
  Purely combinational; the caller owns the beat counter.
*/
`timescale 1ns/10ps
module burst_addr_gen
  import sdram_pkg::*;
#(
  parameter int CW = COL_W
) (
  input  wire logic [CW-1:0] start_col_i, // Column of the command.
  input  wire logic [CW:0]   beat_i,      // Beats already done.
  input  wire logic [2:0]    len_code_i,  // Burst length code.
  input  wire logic          interleave_i, // Interleaved order.
  output logic      [CW-1:0] col_o        // Column of this beat.
);
  logic [CW-1:0] mask;
  logic [CW-1:0] beat;

  // The wrap mask covers the low bits that a burst of this size walks.
  always_comb begin
    beat = beat_i[CW-1:0];
    case (len_code_i)
      BL_2:    mask = CW'(1);
      BL_4:    mask = CW'(3);
      BL_8:    mask = CW'(7);
      BL_PAGE: mask = '1;
      default: mask = '0;
    endcase
    // Full page has no interleaved form, so it always counts upward.
    if (interleave_i && len_code_i != BL_PAGE) begin
      col_o = (start_col_i & ~mask) | ((start_col_i ^ beat) & mask); // [RULE7]
    end else begin
      col_o = (start_col_i & ~mask) | ((start_col_i + beat) & mask); // [RULE4]
    end
  end
endmodule

// *** verilog/sdram_burst_core.sv ***
/*
  Command side of a four-bank 16-bit synchronous DRAM: row open, bursts,
  burst stop, auto precharge, clock gating, power-down and self refresh.
  Assumes the controller logic shares ref_clk_i; read words leave through
  a FIFO whose reader may stall, which pauses a read burst.
*/
`timescale 1ns/10ps
// Operation
// [RULE1] Sample all inputs on rising clock edge.
// [RULE2] Four banks of 2M sixteen-bit words.
// [RULE3] Controller opens row before read or write.
// [RULE4] Burst runs from column in programmed order.
// [RULE5] Clock advances burst counter and output registers.
// [RULE6] Burst length 1, 2, 4, 8 or page.
// [RULE7] Sequential or interleaved order by mode.
// [RULE8] Burst stop ends a running burst early.
// [RULE9] Auto precharge closes row after burst end.
// [RULE10] Low clock gate freezes burst and outputs; the read FIFO still passes words to a ready reader.
// [RULE11] Low gate enters power save only idle.
// [RULE12] Gate asynchronous while in power-down or self refresh.
// [RULE13] Input buffers off in power-down and self refresh.
// [RULE14] Auto and self refresh, 4096 rows per 64ms.
// [RULE15] Controller selects bank with two select bits.
// [RULE16] Controller keeps clock gate high normally.
module sdram_burst_core
  import sdram_pkg::*;
#(
  parameter int ROWS_W = ROW_W,
  parameter int COLS_W = COL_W,
  parameter int DW     = DATA_W,
  parameter int FDEPTH = FIFO_DEPTH
) (
  input  wire logic              ref_clk_i,          // System clock.
  input  wire logic              reset_n_i,          // Async reset, low.
  input  wire logic              cke_i,              // Clock gate.
  input  wire logic              cs_n_i,             // Chip select, low.
  input  wire logic              ras_n_i,            // Row strobe, low.
  input  wire logic              cas_n_i,            // Column strobe, low.
  input  wire logic              we_n_i,             // Write enable, low.
  input  wire logic              bank_select_low_i,  // Bank bit 0.
  input  wire logic              bank_select_high_i, // Bank bit 1.
  input  wire logic [ADDR_W-1:0] addr_i,             // Row/column address.
  input  wire logic [DW-1:0]     wr_data_i,          // Write burst word.
  output logic      [DW-1:0]     rd_data_o,          // Read burst word.
  output logic                   rd_valid_o,         // Read word ready.
  input  wire logic              rd_ready_i,         // Reader takes word.
  output logic      [BANKS-1:0]  bank_open_o,        // Row open per bank.
  output logic                   burst_active_o,     // Burst running.
  output power_e                 power_state_o,      // Power mode.
  output logic                   input_buf_en_o,     // Input buffers on.
  output logic [REFRESH_ROW_W-1:0] refresh_row_o     // Next refresh row.
);
  localparam int CNT_W = COLS_W + 1;
  localparam int MEM_WORDS = BANKS << (ROWS_W + COLS_W);

  cmd_s               cmd;
  cmd_e               op;
  mode_s              mode_reg;
  power_e             power_reg;
  logic               cke_prev_reg;
  logic               cke_meta_reg;
  logic               cke_sync_reg;
  logic               cke_sync_d_reg;
  logic               clk_run;
  logic               all_idle;
  logic               burst_active_reg;
  logic               burst_rd_reg;
  logic               burst_ap_reg;
  logic [BANK_W-1:0]  burst_bank_reg;
  logic [COLS_W-1:0]  burst_col_reg;
  logic [2:0]         burst_code_reg;
  logic               burst_il_reg;
  logic [CNT_W-1:0]   burst_cnt_reg;
  logic [CNT_W-1:0]   burst_len;
  logic               last_beat;
  logic               advance;
  logic               ap_start;
  logic [COLS_W-1:0]  beat_col;
  logic [ROWS_W-1:0]  row_of [BANKS];
  logic               fifo_in_ready;
  logic [DW-1:0]      mem [MEM_WORDS];
  logic [$clog2(MEM_WORDS)-1:0] mem_addr;
  logic [$clog2(REFRESH_INTERVAL_CYC + 1)-1:0] sr_timer_reg;
  logic [REFRESH_ROW_W-1:0] refresh_row_reg;

  // Pins gather into one command word; the edge samples it directly.
  assign cmd = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i,
                 we_n: we_n_i,
                 bank: {bank_select_high_i, bank_select_low_i}, // [RULE15]
                 addr: addr_i};
  // The internal clock runs only if the gate was high one edge earlier.
  assign clk_run = cke_prev_reg && power_reg == PWR_ACTIVE;     // [RULE10]
  assign op = clk_run ? decode_cmd(cmd) : CMD_NOP;              // [RULE1]
  assign all_idle = bank_open_o == '0 && !burst_active_reg;

  // Gate history for suspend, plus a synchroniser for the asynchronous
  // exit from the power-save modes, where no clean edge is guaranteed.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cke_prev_reg <= 1'b0;
      cke_meta_reg <= 1'b0;
      cke_sync_reg <= 1'b0;
      cke_sync_d_reg <= 1'b0;
    end else begin
      cke_prev_reg <= cke_i;                                    // [RULE10]
      cke_meta_reg <= cke_i;                                    // [RULE12]
      cke_sync_reg <= cke_meta_reg;
      cke_sync_d_reg <= cke_sync_reg;
    end
  end

  // Power state: entry only with every bank idle. Exit needs a rising
  // synced gate, as the synchroniser still shows high just after entry.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_reg <= PWR_ACTIVE;
    end else begin
      case (power_reg)
        PWR_ACTIVE: begin
          if (cke_prev_reg && !cke_i && all_idle) begin         // [RULE11]
            power_reg <= (decode_cmd(cmd) == CMD_REFRESH)
                         ? PWR_SELF_REFRESH : PWR_POWER_DOWN;
          end
        end
        default: begin
          if (cke_sync_reg && !cke_sync_d_reg) begin            // [RULE12]
            power_reg <= PWR_ACTIVE;
          end
        end
      endcase
    end
  end
  assign power_state_o  = power_reg;
  assign input_buf_en_o = power_reg == PWR_ACTIVE;              // [RULE13]

  // Mode register: burst length and order, loaded only while idle.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg <= '{burst_len: BL_1, interleave: 1'b0};
    end else if (op == CMD_MODE && all_idle) begin
      mode_reg <= '{burst_len: cmd.addr[BL_MSB:BL_LSB],         // [RULE6]
                    interleave: cmd.addr[BT_BIT]};              // [RULE7]
    end
  end

  // Beats in a burst; unknown codes fall back to a single beat.
  always_comb begin
    case (burst_code_reg)
      BL_2:    burst_len = CNT_W'(2);
      BL_4:    burst_len = CNT_W'(4);
      BL_8:    burst_len = CNT_W'(8);
      BL_PAGE: burst_len = CNT_W'(1) << COLS_W;
      default: burst_len = CNT_W'(1);
    endcase
  end

  // A read beat waits for room; a new read, write or stop takes no beat.
  assign last_beat = burst_cnt_reg == burst_len - 1'b1;
  assign advance   = burst_active_reg && clk_run &&
                     !(op == CMD_READ || op == CMD_WRITE ||
                       op == CMD_STOP) &&
                     (!burst_rd_reg || fifo_in_ready);          // [RULE5]
  assign ap_start  = advance && last_beat && burst_ap_reg;

  // Burst control: a new read or write interrupts the running burst.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      burst_active_reg <= 1'b0;
      burst_rd_reg     <= 1'b0;
      burst_ap_reg     <= 1'b0;
      burst_bank_reg   <= '0;
      burst_col_reg    <= '0;
      burst_code_reg   <= BL_1;
      burst_il_reg     <= 1'b0;
      burst_cnt_reg    <= '0;
    end else if (op == CMD_READ || op == CMD_WRITE) begin
      burst_active_reg <= 1'b1;
      burst_rd_reg     <= op == CMD_READ;
      burst_ap_reg     <= cmd.addr[AP_BIT];                     // [RULE9]
      burst_bank_reg   <= cmd.bank;
      burst_col_reg    <= cmd.addr[COLS_W-1:0];                 // [RULE4]
      burst_code_reg   <= mode_reg.burst_len;                   // [RULE6]
      burst_il_reg     <= mode_reg.interleave;
      burst_cnt_reg    <= '0;
    end else if (op == CMD_STOP) begin
      burst_active_reg <= 1'b0;                                 // [RULE8]
    end else if (advance) begin
      burst_cnt_reg <= burst_cnt_reg + 1'b1;                    // [RULE5]
      if (last_beat) begin
        burst_active_reg <= 1'b0;
      end
    end
  end
  assign burst_active_o = burst_active_reg;

  burst_addr_gen #(
    .CW           (COLS_W)
  ) u_addr_gen (
    .start_col_i  (burst_col_reg),
    .beat_i       (burst_cnt_reg),
    .len_code_i   (burst_code_reg),
    .interleave_i (burst_il_reg),
    .col_o        (beat_col)
  );

  // Flat word address: bank, then open row, then column.
  assign mem_addr = {burst_bank_reg, row_of[burst_bank_reg], beat_col};

  // Array of all four banks; writes land on the beat cycle.
  always_ff @(posedge ref_clk_i) begin
    if (advance && !burst_rd_reg) begin
      mem[mem_addr] <= wr_data_i;                               // [RULE2]
    end
  end

  // Per-bank row state and the self-timed precharge countdown.
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic                      open_reg;
    logic [ROWS_W-1:0]         row_reg;
    logic [$clog2(AUTO_PRE_CYC + 1)-1:0] ap_cnt_reg;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        open_reg   <= 1'b0;
        row_reg    <= '0;
        ap_cnt_reg <= '0;
      end else if (clk_run) begin
        if (ap_start && burst_bank_reg == BANK_W'(b)) begin
          ap_cnt_reg <= $bits(ap_cnt_reg)'(AUTO_PRE_CYC);       // [RULE9]
        end else if (ap_cnt_reg != '0) begin
          ap_cnt_reg <= ap_cnt_reg - 1'b1;
          if (ap_cnt_reg == $bits(ap_cnt_reg)'(1)) begin
            open_reg <= 1'b0;
          end
        end
        if (op == CMD_ACTIVATE && cmd.bank == BANK_W'(b)) begin
          open_reg <= 1'b1;                                     // [RULE3]
          row_reg  <= cmd.addr[ROWS_W-1:0];
        end else if (op == CMD_PRECHARGE &&
                     (cmd.addr[AP_BIT] || cmd.bank == BANK_W'(b))) begin
          open_reg <= 1'b0;
        end
      end
    end
    assign bank_open_o[b] = open_reg;
    assign row_of[b]      = row_reg;
  end

  // Refresh row counter: stepped by auto refresh or the self timer.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refresh_row_reg <= '0;
      sr_timer_reg    <= '0;
    end else if (power_reg == PWR_SELF_REFRESH) begin
      if (sr_timer_reg == '0) begin
        sr_timer_reg    <= $bits(sr_timer_reg)'(REFRESH_INTERVAL_CYC - 1);
        refresh_row_reg <= refresh_row_reg + 1'b1;              // [RULE14]
      end else begin
        sr_timer_reg <= sr_timer_reg - 1'b1;
      end
    end else begin
      sr_timer_reg <= '0;
      if (op == CMD_REFRESH && all_idle) begin
        refresh_row_reg <= refresh_row_reg + 1'b1;              // [RULE14]
      end
    end
  end
  assign refresh_row_o = refresh_row_reg;

  // Read words leave through the FIFO; its fullness stalls the burst.
  sync_fifo #(
    .WIDTH       (DW),
    .DEPTH       (FDEPTH)
  ) u_rd_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (advance && burst_rd_reg),                     // [RULE5]
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem[mem_addr]),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );

  sequence s_burst_done;
    advance && last_beat && !(op == CMD_READ || op == CMD_WRITE);
  endsequence
  sequence s_suspend;
    burst_active_reg && !clk_run;
  endsequence

  property p_last_beat_ends;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_burst_done |=> !burst_active_reg;
  endproperty
  a_last_beat_ends: assert property (p_last_beat_ends) // [RULE6]
    else $error("Burst did not end after its last beat.");

  property p_count_steps;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    advance && !last_beat && op == CMD_NOP
      |=> burst_cnt_reg == $past(burst_cnt_reg) + 1'b1;
  endproperty
  a_count_steps: assert property (p_count_steps) // [RULE5]
    else $error("Burst counter did not step on a beat.");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_suspend |=> $stable(burst_cnt_reg) && $stable(rd_data_o);
  endproperty
  a_freeze: assert property (p_freeze) // [RULE10]
    else $error("Burst state moved while the clock was suspended.");

  property p_stop;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    op == CMD_STOP |=> !burst_active_reg;
  endproperty
  a_stop: assert property (p_stop) // [RULE8]
    else $error("Burst stop did not end the burst.");

  property p_enter_idle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    power_reg == PWR_ACTIVE ##1 power_reg != PWR_ACTIVE
      |-> $past(bank_open_o) == '0;
  endproperty
  a_enter_idle: assert property (p_enter_idle) // [RULE11]
    else $error("Power save entered with a row open.");

  property p_buffers_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    power_reg != PWR_ACTIVE |-> !input_buf_en_o ##1 $stable(bank_open_o);
  endproperty
  a_buffers_off: assert property (p_buffers_off) // [RULE13]
    else $error("Inputs accepted during power save.");

  property p_auto_precharge;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ap_start && cke_i ##1 cke_i [*2]
      |=> !bank_open_o[$past(burst_bank_reg, 3)];
  endproperty
  a_auto_precharge: assert property (p_auto_precharge) // [RULE9]
    else $error("Auto precharge did not close the row in time.");

  property p_self_refresh_rate;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    power_reg == PWR_SELF_REFRESH && sr_timer_reg == '0
      |=> refresh_row_reg == $past(refresh_row_reg) + 1'b1;
  endproperty
  a_self_refresh_rate: assert property (p_self_refresh_rate) // [RULE14]
    else $error("Self refresh did not advance the refresh row.");

  property p_exit_sync;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    power_reg != PWR_ACTIVE && !cke_sync_reg |=> power_reg != PWR_ACTIVE;
  endproperty
  a_exit_sync: assert property (p_exit_sync) // [RULE12]
    else $error("Power save left without a synchronised gate.");
endmodule

// *** verif/ctrl_model.sv ***
/*
  Controller model for the SDRAM core: command pins, write words, gate.
  Assumes a shared clock; every pin changes only at a falling edge.
*/
`timescale 1ns/10ps
module ctrl_model
  import sdram_pkg::*;
(
  input  wire logic         ref_clk_i, // System clock.
  output logic              cke_o,     // Clock gate.
  output cmd_s              cmd_o,     // Command pins.
  output logic [DATA_W-1:0] wr_data_o  // Write word.
);
  logic [DATA_W-1:0] wdat [8]; // Words for the next write burst.
  logic [BANKS-1:0]  opened;   // Banks this model has opened.
  // Gate stays high in normal work so every edge samples a command.
  initial begin
    cke_o = 1'b1;
    cmd_o = '1;
    wr_data_o = '0;
    opened = '0;
  end
  // One command; an access to a closed bank gets a row open first.
  task automatic send(input logic [2:0] op, input logic [1:0] bk,
                      input logic [11:0] ad, input int n);
    if (op inside {OP_READ, OP_WRITE} && !opened[bk])
      send(OP_ACTIVATE, bk, 12'h000, 0);
    @(negedge ref_clk_i);
    cmd_o = {1'b0, op, bk, ad};
    if (op == OP_ACTIVATE) opened[bk] = 1'b1;
    if (op == OP_PRECHARGE && ad[AP_BIT]) opened = '0;
    else if (op == OP_PRECHARGE || op inside {OP_READ, OP_WRITE} && ad[AP_BIT])
      opened[bk] = 1'b0;
    @(negedge ref_clk_i);
    cmd_o = {1'b1, 3'h7, 2'h0, ~ad}; // Released pins show no stale value.
    for (int k = 0; k < n; k++) begin
      wr_data_o = wdat[k];
      @(negedge ref_clk_i);
    end
    wr_data_o = ~wr_data_o;
  endtask
  // Power save is only entered with every bank closed.
  task automatic sleep(input logic self_ref);
    send(OP_PRECHARGE, 2'h0, 12'h400, 0);
    @(negedge ref_clk_i);
    cke_o = 1'b0;
    cmd_o = {~self_ref, OP_REFRESH, 2'h0, 12'h000};
    @(negedge ref_clk_i);
    cmd_o.cs_n = 1'b1;
  endtask
  // Gate level for a clock suspend or a power-save exit.
  task automatic gate(input logic v);
    @(negedge ref_clk_i);
    cke_o = v;
  endtask
endmodule

// *** verif/tb.sv ***
/*
  Self-checking bench for the SDRAM burst core.
  Assumes ctrl_model drives commands; the bench owns reset and the reader.
*/
`timescale 1ns/10ps
module tb
  import sdram_pkg::*;
;
  logic                     ref_clk_i, reset_n_i, rd_ready, rd_valid;
  logic                     cke, busy, buf_en, il;
  cmd_s                     cmd;
  logic [DATA_W-1:0]        wr_data, rd_data, mem [8];
  logic [DATA_W-1:0]        rq [$];
  logic [BANKS-1:0]         bank_open;
  power_e                   pwr;
  logic [REFRESH_ROW_W-1:0] rrow, r0;
  int                       fails, tests_run, n, lc, col;
  // Free-running 20 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  ctrl_model ctrl_model_i (.ref_clk_i(ref_clk_i), .cke_o(cke), .cmd_o(cmd),
    .wr_data_o(wr_data));
  // Small array sizes keep the simulated storage cheap.
  sdram_burst_core #(.ROWS_W(4), .COLS_W(4)) sdram_burst_core_i (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cke_i(cke),
    .cs_n_i(cmd.cs_n), .ras_n_i(cmd.ras_n), .cas_n_i(cmd.cas_n),
    .we_n_i(cmd.we_n), .bank_select_low_i(cmd.bank[0]),
    .bank_select_high_i(cmd.bank[1]), .addr_i(cmd.addr),
    .wr_data_i(wr_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .rd_ready_i(rd_ready), .bank_open_o(bank_open), .burst_active_o(busy),
    .power_state_o(pwr), .input_buf_en_o(buf_en), .refresh_row_o(rrow));
  // Reader side: every accepted word is queued for comparison.
  always @(posedge ref_clk_i) if (rd_valid && rd_ready) rq.push_back(rd_data);
  task automatic chk(input string nm, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask
  task automatic report_and_stop();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the burst to end; the reader stalls at random unless
  // the count is negative, which ignores words and drains at full rate.
  task automatic wait_done(input int want);
    int t;
    t = 0;
    while (!((want < 0 || rq.size() == want) && busy === 1'b0)) begin
      rd_ready = (want < 0) | 1'($urandom);
      @(negedge ref_clk_i);
      if (++t > 300) begin
        fails++;
        report_and_stop();
      end
    end
  endtask
  // Column of beat k: wrap inside the burst block, or xor when interleaved.
  function automatic int ecol(int s, int k, int lc, logic il);
    int m;
    m = (1 << lc) - 1;
    return il ? (s ^ k) : ((s & ~m) | ((s + k) & m));
  endfunction
  // Mode can only change with all banks closed, so close them first.
  task automatic rd(input int lc, input logic il, input int col);
    ctrl_model_i.send(OP_PRECHARGE, 2'h0, 12'h400, 0);
    ctrl_model_i.send(OP_MODE, 2'h0, {8'h00, il, lc[2:0]}, 0);
    rq.delete();
    ctrl_model_i.send(OP_READ, 2'(n), col[11:0], 0);
  endtask
  task automatic cmp(input int lc, input logic il, input int col);
    wait_done(1 << lc);
    for (int k = 0; k < (1 << lc); k++)
      chk("rd_data", mem[ecol(col, k, lc, il)], rq[k]);
  endtask
  initial begin
    fails = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    rd_ready = 1'b1;
    void'($urandom(95));
    repeat (4) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk("bank_open", 0, bank_open);
    chk("buf_en", 1, buf_en);
    foreach (mem[k]) mem[k] = 16'($urandom);
    ctrl_model_i.wdat = mem;
    ctrl_model_i.send(OP_MODE, 2'h0, {9'h000, BL_8}, 0);
    for (int b = 0; b < BANKS; b++)
      ctrl_model_i.send(OP_WRITE, 2'(b), 12'h000, 8);
    chk("bank_open", 4'hf, bank_open);
    wait_done(0);
    $display("test write done");
    // Two corner reads at the block's top column, then random ones.
    for (int i = 0; i < 14; i++) begin
      lc = (i == 0) ? 3 : (i == 1) ? 1 : $urandom % 4;
      il = (i == 0) ? 1'b1 : 1'($urandom);
      col = (i < 2) ? 7 : $urandom % 8;
      n = $urandom % 4;
      rd(lc, il, col);
      cmp(lc, il, col);
    end
    $display("test reads done");
    rd_ready = 1'b0;
    rd(3, 1'b0, 0);
    repeat (12) @(negedge ref_clk_i);
    chk("paused", 1, busy);
    chk("fifo_valid", 1, rd_valid);
    cmp(3, 1'b0, 0);
    $display("test stall done");
    rd(3, 1'b0, 0);
    ctrl_model_i.send(OP_STOP, 2'h2, 12'h000, 0);
    wait_done(-1);
    chk("stopped_short", 1, rq.size() < 8);
    rd(0, 1'b0, 32'h403);
    cmp(0, 1'b0, 3);
    repeat (4) @(negedge ref_clk_i);
    chk("auto_pre", 0, bank_open[n]);
    $display("test stop and precharge done");
    rd_ready = 1'b0;
    rd(2, 1'b0, 0);
    ctrl_model_i.gate(1'b0);
    repeat (6) @(negedge ref_clk_i);
    chk("frozen_busy", 1, busy);
    chk("suspend_only", PWR_ACTIVE, pwr);
    ctrl_model_i.gate(1'b1);
    @(negedge ref_clk_i); // Reader waits out the last frozen cycle.
    cmp(2, 1'b0, 0);
    $display("test suspend done");
    ctrl_model_i.send(OP_PRECHARGE, 2'h0, 12'h400, 0);
    r0 = rrow;
    ctrl_model_i.send(OP_REFRESH, 2'h0, 12'h000, 0);
    chk("auto_refresh", r0 + 1'b1, rrow);
    ctrl_model_i.sleep(1'b0);
    chk("power_down", PWR_POWER_DOWN, pwr);
    chk("buf_off", 0, buf_en);
    ctrl_model_i.gate(1'b1);
    repeat (4) @(negedge ref_clk_i);
    chk("wake", PWR_ACTIVE, pwr);
    ctrl_model_i.sleep(1'b1);
    chk("self_refresh", PWR_SELF_REFRESH, pwr);
    r0 = rrow;
    repeat (320) @(negedge ref_clk_i);
    chk("sr_rows", r0 + 1 + 320 / REFRESH_INTERVAL_CYC, rrow);
    ctrl_model_i.gate(1'b1);
    repeat (4) @(negedge ref_clk_i);
    chk("wake", PWR_ACTIVE, pwr);
    $display("test power done");
    report_and_stop();
  end
endmodule
